/* hdl/ots_supervisor.sv */
`timescale 1ns/1ps
module ots_supervisor #(
    parameter int CYC_PER_MS = ots_pkg::CYC_PER_MS
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic cmd_write_i,
    input wire logic cmd_read_i,
    input wire logic cmd_word_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [15:0] cmd_wdata_i,
    input wire logic [15:0] temp_reading_i,
    input wire logic [15:0] trip_threshold_i,
    input wire logic [7:0] rampup_ms_i,
    input wire logic on_cmd_i,
    input wire logic startup_ok_i,
    input wire logic clear_faults_i,
    input wire logic nvm_restore_i,
    output logic [15:0] cmd_rdata_o,
    output logic cmd_ack_o,
    output logic power_enable_o,
    output logic latched_off_o,
    output logic status_temp_o,
    output logic thermal_fault_flag_o,
    output logic thermal_warning_flag_o,
    output logic cml_flag_o,
    output logic alert_n_o
);
    // ************************************************
    // Declarations
    // ************************************************
    logic [7:0] resp_q;
    logic [15:0] warn_word_q;
    logic fault_act_q;
    logic [2:0] att_q;
    ots_pkg::ots_state_t fsm_q;
    ots_pkg::ots_state_t fsm_d;
    logic [1:0] fault_action_select;
    logic [2:0] restart_attempt_count;
    logic [2:0] shutdown_delay_code;
    logic signed [31:0] temp_q2, trip_q2, warn_q2, wdata_q2, release_q2, warn_round;
    logic trip_en, warn_en, warn_usable, above_trip, above_warn, below_release, trip_evt;
    logic wr_resp, wr_warn, rd_resp, rd_warn, resp_ok, warn_ok, bad_cmd;
    logic fault_flag_d, warn_flag_d, summary_d, cml_d;
    logic [15:0] delay_ms, output_rampup_time, restart_wait_period, restart_wait_period_mult, tmr_load;
    logic tmr_start, tmr_stop, tmr_done, att_inc, att_clr, go_shut;

    assign fault_action_select = resp_q[ots_pkg::ACT_MSB:ots_pkg::ACT_LSB];
    assign restart_attempt_count = resp_q[ots_pkg::RETRY_MSB:ots_pkg::RETRY_LSB];
    assign shutdown_delay_code = resp_q[ots_pkg::DELAY_MSB:ots_pkg::DELAY_LSB];

    // ************************************************
    // Threshold comparison
    // ************************************************
    assign temp_q2 = ots_pkg::lin_to_q2(temp_reading_i);
    assign trip_q2 = ots_pkg::lin_to_q2(trip_threshold_i);
    assign warn_q2 = ots_pkg::lin_to_q2(warn_word_q);
    assign wdata_q2 = ots_pkg::lin_to_q2(cmd_wdata_i);
    assign trip_en = (trip_q2 != ots_pkg::DISABLE_Q2);
    assign warn_en = (warn_q2 != ots_pkg::DISABLE_Q2);
    assign warn_usable = warn_en && (warn_q2 <= trip_q2);
    assign release_q2 = warn_usable ? warn_q2 : (trip_q2 - ots_pkg::HYST_Q2);
    assign above_trip = trip_en && (temp_q2 > trip_q2);
    assign above_warn = warn_en && (temp_q2 > warn_q2);
    assign below_release = (temp_q2 < release_q2);
    assign trip_evt = above_trip && !fault_act_q;

    // Fault stays active through the hysteresis band
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fault_act_q <= 1'b0;
        end else if (above_trip) begin
            fault_act_q <= 1'b1;
        end else if (below_release) begin
            fault_act_q <= 1'b0;
        end
    end

    // ************************************************
    // Command decode
    // ************************************************
    assign wr_resp = cmd_write_i && (cmd_code_i == ots_pkg::CMD_RESPONSE);
    assign wr_warn = cmd_write_i && (cmd_code_i == ots_pkg::CMD_WARN_LIMIT);
    assign rd_resp = cmd_read_i && (cmd_code_i == ots_pkg::CMD_RESPONSE);
    assign rd_warn = cmd_read_i && (cmd_code_i == ots_pkg::CMD_WARN_LIMIT);
    assign resp_ok = wr_resp && !cmd_word_i;
    assign warn_ok = wr_warn && cmd_word_i && (wdata_q2 >= ots_pkg::WARN_MIN_Q2)
        && (wdata_q2 <= ots_pkg::DISABLE_Q2);
    // Wrong transfer size or out-of-range limit is refused
    assign bad_cmd = (wr_resp && cmd_word_i) || (wr_warn && !warn_ok)
        || (rd_resp && cmd_word_i) || (rd_warn && !cmd_word_i);

    always_comb begin
        warn_round = (warn_q2 + ots_pkg::HALF_DEG_Q2) >>> ots_pkg::Q2_SHIFT;
        if (warn_round < ots_pkg::NVM_MIN_DEG) begin
            warn_round = ots_pkg::NVM_MIN_DEG;
        end
        if (warn_round > ots_pkg::NVM_MAX_DEG) begin
            warn_round = ots_pkg::NVM_MAX_DEG;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            resp_q <= ots_pkg::RESPONSE_RESET;
        end else if (resp_ok) begin
            resp_q <= cmd_wdata_i[7:0];
        end
    end

    // A host write in the same cycle beats a restore
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            warn_word_q <= ots_pkg::WARN_RESET;
        end else if (warn_ok) begin
            warn_word_q <= cmd_wdata_i;
        end else if (nvm_restore_i && warn_en) begin
            warn_word_q <= {ots_pkg::WARN_EXP_RESET, warn_round[10:0]};
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cmd_rdata_o <= 16'h0;
            cmd_ack_o <= 1'b0;
        end else begin
            cmd_ack_o <= rd_resp || rd_warn;
            if (rd_resp && !cmd_word_i) begin
                cmd_rdata_o <= {8'h00, resp_q};
            end else if (rd_warn && cmd_word_i) begin
                cmd_rdata_o <= warn_word_q;
            end else begin
                cmd_rdata_o <= 16'h0;
            end
        end
    end

    // ************************************************
    // Status flags, set wins over clear
    // ************************************************
    assign fault_flag_d = (thermal_fault_flag_o && !clear_faults_i) || trip_evt;
    assign warn_flag_d = (thermal_warning_flag_o && !clear_faults_i) || above_warn;
    assign summary_d = (status_temp_o && !clear_faults_i) || trip_evt || above_warn;
    assign cml_d = (cml_flag_o && !clear_faults_i) || bad_cmd;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            thermal_fault_flag_o <= 1'b0;
            thermal_warning_flag_o <= 1'b0;
            status_temp_o <= 1'b0;
            cml_flag_o <= 1'b0;
            alert_n_o <= 1'b1;
        end else begin
            thermal_fault_flag_o <= fault_flag_d;
            thermal_warning_flag_o <= warn_flag_d;
            status_temp_o <= summary_d;
            cml_flag_o <= cml_d;
            alert_n_o <= !(fault_flag_d || warn_flag_d || cml_d);
        end
    end

    // ************************************************
    // Delay and restart_wait_period periods
    // ************************************************
    always_comb begin
        if (shutdown_delay_code == ots_pkg::DELAY_DEFAULT_CODE) begin
            delay_ms = ots_pkg::SHUT_DELAY_DEFAULT_MS;
            restart_wait_period_mult = 16'h1;
        end else begin
            delay_ms = {13'h0, shutdown_delay_code};
            if (shutdown_delay_code < ots_pkg::RESTART_WAIT_PERIOD_X3_CODE) begin
                restart_wait_period_mult = 16'h2;
            end else if (shutdown_delay_code < ots_pkg::RESTART_WAIT_PERIOD_X4_CODE) begin
                restart_wait_period_mult = 16'h3;
            end else begin
                restart_wait_period_mult = 16'h4;
            end
        end
    end

    assign output_rampup_time = {8'h00, rampup_ms_i};
    assign restart_wait_period = 16'(output_rampup_time * restart_wait_period_mult);

    ots_ms_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_timer (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .start_i(tmr_start),
        .stop_i(tmr_stop),
        .load_ms_i(tmr_load),
        .done_o(tmr_done)
    );

    // ************************************************
    // Response state machine
    // ************************************************
    always_comb begin
        fsm_d = fsm_q;
        tmr_start = 1'b0;
        tmr_stop = 1'b0;
        tmr_load = restart_wait_period;
        att_inc = 1'b0;
        att_clr = 1'b0;
        go_shut = 1'b0;
        if (!on_cmd_i) begin
            fsm_d = ots_pkg::ST_OFF;
            tmr_stop = 1'b1;
            att_clr = 1'b1;
        end else begin
            case (fsm_q)
                ots_pkg::ST_OFF: begin
                    fsm_d = ots_pkg::ST_RUN;
                end
                ots_pkg::ST_RUN: begin
                    if (startup_ok_i) begin
                        att_clr = 1'b1;
                    end
                    if (fault_act_q) begin
                        case (fault_action_select)
                            ots_pkg::ACT_IGNORE: fsm_d = ots_pkg::ST_RUN;
                            ots_pkg::ACT_DELAYED: begin
                                fsm_d = ots_pkg::ST_DELAY;
                                tmr_start = 1'b1;
                                tmr_load = delay_ms;
                            end
                            ots_pkg::ACT_IMMEDIATE: go_shut = 1'b1;
                            default: fsm_d = ots_pkg::ST_HOLD;
                        endcase
                    end
                end
                ots_pkg::ST_DELAY: begin
                    if (!fault_act_q) begin
                        fsm_d = ots_pkg::ST_RUN;
                        tmr_stop = 1'b1;
                    end else if (tmr_done) begin
                        go_shut = 1'b1;
                    end
                end
                ots_pkg::ST_HOLD: begin
                    if (!fault_act_q) begin
                        go_shut = 1'b1;
                    end
                end
                ots_pkg::ST_RESTART_WAIT_PERIOD: begin
                    if (tmr_done) begin
                        if (restart_attempt_count != ots_pkg::RETRY_FOREVER
                                && att_q >= restart_attempt_count) begin
                            fsm_d = ots_pkg::ST_LATCH;
                        end else begin
                            att_inc = 1'b1;
                            if (fault_act_q) begin
                                tmr_start = 1'b1;
                            end else begin
                                fsm_d = ots_pkg::ST_RUN;
                            end
                        end
                    end
                end
                ots_pkg::ST_LATCH: begin
                    fsm_d = ots_pkg::ST_LATCH;
                end
                default: begin
                    fsm_d = ots_pkg::ST_OFF;
                end
            endcase
            // Common shutdown path into retry policy
            if (go_shut) begin
                if (restart_attempt_count == ots_pkg::RETRY_NONE) begin
                    fsm_d = ots_pkg::ST_LATCH;
                end else begin
                    fsm_d = ots_pkg::ST_RESTART_WAIT_PERIOD;
                    tmr_start = 1'b1;
                    tmr_load = restart_wait_period;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fsm_q <= ots_pkg::ST_OFF;
            power_enable_o <= 1'b0;
            latched_off_o <= 1'b0;
        end else begin
            fsm_q <= fsm_d;
            power_enable_o <= (fsm_d == ots_pkg::ST_RUN) || (fsm_d == ots_pkg::ST_DELAY);
            latched_off_o <= (fsm_d == ots_pkg::ST_LATCH);
        end
    end

    // Saturates so the endless mode never wraps
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            att_q <= 3'h0;
        end else if (att_clr) begin
            att_q <= 3'h0;
        end else if (att_inc && att_q != ots_pkg::RETRY_FOREVER) begin
            att_q <= att_q + 3'h1;
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    a_resp_write: assert property (
        resp_ok |=> resp_q == $past(cmd_wdata_i[7:0]))
        else $error("response byte not stored");
    a_fault_flags: assert property (
        trip_evt |=> thermal_fault_flag_o && status_temp_o && !alert_n_o)
        else $error("fault flags or alert missing");
    a_release_fault: assert property (
        fault_act_q && !above_trip && below_release |=> !fault_act_q)
        else $error("fault not released below release level");
    a_hyst_default: assert property (
        !warn_usable |-> release_q2 == trip_q2 - ots_pkg::HYST_Q2)
        else $error("default hysteresis not used");
    a_ignore_runs: assert property (
        fsm_q == ots_pkg::ST_RUN && fault_act_q && on_cmd_i
            && fault_action_select == ots_pkg::ACT_IGNORE |=> power_enable_o)
        else $error("ignore action stopped the output");
    a_immediate_off: assert property (
        fsm_q == ots_pkg::ST_RUN && fault_act_q && on_cmd_i
            && fault_action_select == ots_pkg::ACT_IMMEDIATE |=> !power_enable_o)
        else $error("immediate shutdown did not stop output");
    a_hold_stays: assert property (
        fsm_q == ots_pkg::ST_HOLD && fault_act_q && on_cmd_i |=> !power_enable_o [*2])
        else $error("hold released while fault active");
    a_latch_none: assert property (
        go_shut && on_cmd_i && restart_attempt_count == ots_pkg::RETRY_NONE
            |=> latched_off_o)
        else $error("retry zero did not latch off");
    a_attempt_bound: assert property (
        fsm_q == ots_pkg::ST_RESTART_WAIT_PERIOD && restart_attempt_count != ots_pkg::RETRY_FOREVER
            |-> att_q <= restart_attempt_count || !on_cmd_i)
        else $error("attempts exceed retry limit");
    a_hidden_count: assert property (
        fsm_q == ots_pkg::ST_RESTART_WAIT_PERIOD && tmr_done && fault_act_q && att_inc && att_q < 3'h6
            |=> att_q == $past(att_q) + 3'h1)
        else $error("hidden restart not counted");
    a_bad_write: assert property (
        wr_resp && cmd_word_i |=> cml_flag_o && resp_q == $past(resp_q) && !alert_n_o)
        else $error("invalid write not flagged");
    a_warn_flag: assert property (
        above_warn |=> thermal_warning_flag_o && status_temp_o)
        else $error("warning flag not set");
    a_warn_disable: assert property (
        !warn_en && !clear_faults_i |=> $stable(thermal_warning_flag_o))
        else $error("warning raised while disabled");

    c_delayed_shut: cover property (
        fsm_q == ots_pkg::ST_DELAY ##1 fsm_q == ots_pkg::ST_RESTART_WAIT_PERIOD);
    c_restart_wait_period_restart: cover property (
        fsm_q == ots_pkg::ST_RESTART_WAIT_PERIOD ##1 fsm_q == ots_pkg::ST_RUN);
    c_latch: cover property (fsm_q == ots_pkg::ST_RESTART_WAIT_PERIOD ##1 latched_off_o);
    c_hold_release: cover property (
        fsm_q == ots_pkg::ST_HOLD ##1 fsm_q == ots_pkg::ST_RESTART_WAIT_PERIOD);
endmodule

/* hdl/ots_pkg.sv */
// Summary of operation
// - Response byte at 50h, byte access, immediate.
// - Fault sets summary, fault flag, alerts host.
// - Fault released below warning threshold; restart allowed.
// - Warning above trip or disabled: 20C hysteresis.
// - Action 00b ignores the fault.
// - Action 01b: delay, then shut down.
// - Action 10b: shut down immediately, then retry.
// - Action 11b: hold off until below warning.
// - Retry 0: latch off after shutdown.
// - Retry 1-6: restart_wait_period wait, limited attempts, latch.
// - Hidden restarts while hot still count.
// - Retry 7: retry forever until off/success.
// - Delay code 0: 10ms delay, restart_wait_period equals rampup.
// - Delay codes 1-7: 1-7ms, restart_wait_period 2-4x rampup.
// - Unsupported writes rejected, flag set, host alerted.
// - Action 11b on command may stay faulted.
// - Warning threshold word at 51h, word access.
// - Warning word: exponent 15:11, mantissa 10:0.
// - Warning crossing sets summary, warning flag, alert.
// - Restore rounds warning to whole degree 0-160C.
// - Warning threshold 255C disables warning detection.
// - Above trip threshold declares fault; 255C disables.
package ots_pkg;
    // ************************************************
    // Command codes and field layout
    // ************************************************
    localparam logic [7:0] CMD_RESPONSE = 8'h50;
    localparam logic [7:0] CMD_WARN_LIMIT = 8'h51;
    localparam int ACT_MSB = 7;
    localparam int ACT_LSB = 6;
    localparam int RETRY_MSB = 5;
    localparam int RETRY_LSB = 3;
    localparam int DELAY_MSB = 2;
    localparam int DELAY_LSB = 0;
    localparam int LIN_EXP_MSB = 15;
    localparam int LIN_EXP_LSB = 11;
    localparam int LIN_MAN_MSB = 10;
    localparam logic [1:0] ACT_IGNORE = 2'h0;
    localparam logic [1:0] ACT_DELAYED = 2'h1;
    localparam logic [1:0] ACT_IMMEDIATE = 2'h2;
    localparam logic [1:0] ACT_HOLD = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    localparam logic [2:0] DELAY_DEFAULT_CODE = 3'h0;
    localparam logic [2:0] RESTART_WAIT_PERIOD_X3_CODE = 3'h4;
    localparam logic [2:0] RESTART_WAIT_PERIOD_X4_CODE = 3'h7;
    localparam logic [7:0] RESPONSE_RESET = 8'h80;
    localparam logic [15:0] WARN_RESET = 16'h0073;
    localparam logic [4:0] WARN_EXP_RESET = 5'h00;

    // ************************************************
    // Temperatures, held in quarter degrees
    // ************************************************
    localparam int Q2_SHIFT = 2;
    localparam logic signed [5:0] Q2_EXP_BIAS = 6'sh02;
    localparam logic signed [31:0] HALF_DEG_Q2 = 32'sh2;
    localparam logic signed [31:0] DISABLE_Q2 = 32'sh3fc;
    localparam logic signed [31:0] HYST_Q2 = 32'sh50;
    localparam logic signed [31:0] WARN_MIN_Q2 = 32'sh0;
    localparam logic signed [31:0] NVM_MIN_DEG = 32'sh0;
    localparam logic signed [31:0] NVM_MAX_DEG = 32'sha0;

    // ************************************************
    // Timing
    // ************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
    localparam logic [15:0] SHUT_DELAY_DEFAULT_MS = 16'h000a;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_RUN,
        ST_DELAY,
        ST_HOLD,
        ST_RESTART_WAIT_PERIOD,
        ST_LATCH
    } ots_state_t;

    // Linear word to signed quarter degrees
    function automatic logic signed [31:0] lin_to_q2(input logic [15:0] w);
        logic signed [5:0] sh;
        logic [5:0] nsh;
        logic signed [31:0] m;
        sh = $signed({w[LIN_EXP_MSB], w[LIN_EXP_MSB:LIN_EXP_LSB]}) + Q2_EXP_BIAS;
        nsh = 6'(-sh);
        m = {{21{w[LIN_MAN_MSB]}}, w[LIN_MAN_MSB:0]};
        if (!sh[5]) begin
            lin_to_q2 = m <<< sh[4:0];
        end else begin
            lin_to_q2 = m >>> nsh[4:0];
        end
    endfunction
endpackage

/* hdl/ots_ms_timer.sv */
`timescale 1ns/1ps
module ots_ms_timer #(
    parameter int CYC_PER_MS = ots_pkg::CYC_PER_MS
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic [15:0] load_ms_i,
    output logic done_o
);
    // ************************************************
    // Millisecond prescaler and down counter
    // ************************************************
    logic [31:0] pre_q;
    logic [15:0] ms_q;
    logic busy_q;
    logic tick;

    assign tick = (pre_q == 32'(CYC_PER_MS - 1));

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pre_q <= 32'h0;
        end else if (start_i || stop_i || tick) begin
            pre_q <= 32'h0;
        end else if (busy_q) begin
            pre_q <= pre_q + 32'h1;
        end
    end

    // Zero load still waits one full tick
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ms_q <= 16'h0;
            busy_q <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (stop_i) begin
                busy_q <= 1'b0;
            end else if (start_i) begin
                ms_q <= (load_ms_i == 16'h0) ? 16'h1 : load_ms_i;
                busy_q <= 1'b1;
            end else if (busy_q && tick) begin
                ms_q <= ms_q - 16'h1;
                if (ms_q == 16'h1) begin
                    busy_q <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end
endmodule

/* verification/ots_host_model.sv */
`timescale 1ns/1ps
module ots_host_model (
    input wire logic clk_i,
    input wire logic [15:0] cmd_rdata_i,
    input wire logic cmd_ack_i,
    output logic cmd_write_o,
    output logic cmd_read_o,
    output logic cmd_word_o,
    output logic [7:0] cmd_code_o,
    output logic [15:0] cmd_wdata_o
);
    initial begin
        cmd_write_o = 1'b0;
        cmd_read_o = 1'b0;
        cmd_word_o = 1'b0;
        cmd_code_o = 8'h00;
        cmd_wdata_o = 16'h0000;
    end
    // One request per call; released data is inverted so stale values never match
    task automatic xfer(input logic wr, input logic word, input logic [7:0] code,
                        input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_i);
        cmd_write_o <= wr;
        cmd_read_o <= !wr;
        cmd_word_o <= word;
        cmd_code_o <= code;
        cmd_wdata_o <= d;
        @(posedge clk_i);
        cmd_write_o <= 1'b0;
        cmd_read_o <= 1'b0;
        cmd_wdata_o <= ~d;
        cmd_code_o <= ~code;
        @(posedge clk_i);
        q = cmd_ack_i ? cmd_rdata_i : 16'hdead;
    endtask
endmodule

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
    logic clk_i, reset_n_i, on_cmd_i, startup_ok_i, clear_faults_i, nvm_restore_i;
    logic [15:0] temp_reading_i, trip_threshold_i, q;
    logic [7:0] rampup_ms_i, cmd_code_i;
    logic cmd_write_i, cmd_read_i, cmd_word_i, cmd_ack_o, power_enable_o, latched_off_o;
    logic status_temp_o, thermal_fault_flag_o, thermal_warning_flag_o, cml_flag_o, alert_n_o;
    logic [15:0] cmd_wdata_i, cmd_rdata_o, flg;
    int n_fail = 0;
    int num_checks = 0;
    assign flg = {9'h0, power_enable_o, latched_off_o, status_temp_o, thermal_fault_flag_o,
                  thermal_warning_flag_o, cml_flag_o, alert_n_o};
    ots_supervisor #(.CYC_PER_MS(10)) u_ots_supervisor (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .cmd_write_i(cmd_write_i), .cmd_read_i(cmd_read_i), .cmd_word_i(cmd_word_i),
        .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i), .temp_reading_i(temp_reading_i),
        .trip_threshold_i(trip_threshold_i), .rampup_ms_i(rampup_ms_i), .on_cmd_i(on_cmd_i),
        .startup_ok_i(startup_ok_i), .clear_faults_i(clear_faults_i),
        .nvm_restore_i(nvm_restore_i), .cmd_rdata_o(cmd_rdata_o), .cmd_ack_o(cmd_ack_o),
        .power_enable_o(power_enable_o), .latched_off_o(latched_off_o),
        .status_temp_o(status_temp_o), .thermal_fault_flag_o(thermal_fault_flag_o),
        .thermal_warning_flag_o(thermal_warning_flag_o), .cml_flag_o(cml_flag_o),
        .alert_n_o(alert_n_o));
    ots_host_model u_ots_host_model (.clk_i(clk_i), .cmd_rdata_i(cmd_rdata_o),
        .cmd_ack_i(cmd_ack_o), .cmd_write_o(cmd_write_i), .cmd_read_o(cmd_read_i),
        .cmd_word_o(cmd_word_i), .cmd_code_o(cmd_code_i), .cmd_wdata_o(cmd_wdata_i));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic w, input logic [7:0] c, input logic [15:0] d);
        u_ots_host_model.xfer(1'b1, w, c, d, q);
    endtask
    task automatic rd(input logic w, input logic [7:0] c, input logic [15:0] exp);
        u_ots_host_model.xfer(1'b0, w, c, 16'h0000, q);
        chk(q, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic tmp(input logic [15:0] t);
        @(posedge clk_i);
        temp_reading_i <= t;
    endtask
    task automatic clr();
        @(posedge clk_i);
        clear_faults_i <= 1'b1;
        @(posedge clk_i);
        clear_faults_i <= 1'b0;
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        #100000;
        n_fail++;
        end_sim();
    end
    initial begin
        reset_n_i = 1'b0;
        {on_cmd_i, startup_ok_i, clear_faults_i, nvm_restore_i} = 4'h8;
        temp_reading_i = 16'h0064;
        trip_threshold_i = 16'h007d;
        rampup_ms_i = 8'h01;
        cyc(2);
        reset_n_i <= 1'b1;
        cyc(4);
        chk(flg, 16'h0041);
        rd(1'b1, 8'h51, 16'h0073);
        rd(1'b0, 8'h50, 16'h0080);
        wr(1'b0, 8'h50, 16'h009a);
        rd(1'b0, 8'h50, 16'h009a);
        wr(1'b1, 8'h50, 16'h1234);
        cyc(1);
        chk(flg & 16'h0003, 16'h0002);
        rd(1'b0, 8'h50, 16'h009a);
        wr(1'b0, 8'h50, 16'h0080);
        clr();
        tmp(16'h0082);
        cyc(30);
        chk(flg, 16'h003c);
        tmp(16'h0064);
        on_cmd_i <= 1'b0;
        clr();
        on_cmd_i <= 1'b1;
        cyc(4);
        chk(flg, 16'h0041);
        wr(1'b0, 8'h50, 16'h0000);
        tmp(16'h0082);
        cyc(30);
        chk(flg, 16'h005c);
        wr(1'b0, 8'h50, 16'h0090);
        tmp(16'h0064);
        clr();
        tmp(16'h0082);
        cyc(12);
        chk(flg & 16'h0060, 16'h0000);
        tmp(16'h0064);
        cyc(40);
        chk(flg & 16'h0060, 16'h0040);
        tmp(16'h0082);
        cyc(16);
        chk(flg & 16'h0060, 16'h0020);
        clr();
        tmp(16'h0078);
        cyc(3);
        chk(flg & 16'h001d, 16'h0014);
        wr(1'b1, 8'h51, 16'h00ff);
        clr();
        cyc(3);
        chk(flg & 16'h001d, 16'h0001);
        wr(1'b1, 8'h51, 16'hf8e7);
        @(posedge clk_i);
        nvm_restore_i <= 1'b1;
        @(posedge clk_i);
        nvm_restore_i <= 1'b0;
        rd(1'b1, 8'h51, 16'h0074);
        tmp(16'h0064);
        on_cmd_i <= 1'b0;
        wr(1'b0, 8'h50, 16'h0051);
        on_cmd_i <= 1'b1;
        tmp(16'h0082);
        cyc(5);
        chk(flg & 16'h0060, 16'h0040);
        cyc(10);
        chk(flg & 16'h0060, 16'h0000);
        on_cmd_i <= 1'b0;
        wr(1'b0, 8'h50, 16'h00d0);
        on_cmd_i <= 1'b1;
        cyc(20);
        chk(flg & 16'h0060, 16'h0000);
        tmp(16'h0064);
        cyc(20);
        chk(flg & 16'h0060, 16'h0040);
        end_sim();
    end
endmodule
